// >>> core/psmts_pkg.sv
// Constants for the port line mode, station address and transmit statistics block.
package psmts_pkg;

    // ====================================================================
    // Register map (byte addresses on APB)
    // ====================================================================
    localparam logic [11:0] ADDR_MODE = 12'h000;
    localparam logic [11:0] ADDR_LINK = 12'h004;
    localparam logic [11:0] ADDR_SA_LO = 12'h008;
    localparam logic [11:0] ADDR_SA_HI = 12'h00c;
    localparam logic [11:0] STAT_CLR_BASE = 12'h100;
    localparam logic [11:0] STAT_KEEP_BASE = 12'h200;

    // ====================================================================
    // Statistic counters
    // ====================================================================
    localparam int NUM_CNT = 19;
    localparam int IDX_UNI = 0;
    localparam int IDX_MLT = 1;
    localparam int IDX_BRD = 2;
    localparam int IDX_DEFER = 3;
    localparam int IDX_COLL = 4;
    localparam int IDX_SCOL = 5;
    localparam int IDX_MCOL = 6;
    localparam int IDX_XCOL = 7;
    localparam int IDX_LCOL = 8;
    localparam int IDX_BIN0 = 9;
    localparam int IDX_OVER = 15;
    localparam int IDX_PAUSE = 16;
    localparam int IDX_ERR = 17;
    localparam int IDX_BYTES = 18;
    localparam logic [11:0] CNT_OFS [NUM_CNT] = '{
        12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c,
        12'h020, 12'h024, 12'h028, 12'h02c, 12'h030, 12'h034, 12'h038, 12'h03c,
        12'h040, 12'h044, 12'h060};
    localparam logic [11:0] OFS_BYTES_HI = 12'h064;
    localparam int FRAME_CW = 32;
    localparam int BYTE_CW = 40;

    // ====================================================================
    // Field positions and reset values
    // ====================================================================
    localparam int BIT_SYP = 0;
    localparam int BIT_SCR = 1;
    localparam int BIT_FDX = 3;
    localparam int BIT_EXTERNAL_LOOPBACK = 4;
    localparam int BIT_INTERNAL_LOOPBACK = 5;
    localparam logic [7:0] MODE_WMASK = 8'h3b;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [47:0] SA_RESET = 48'h0;
    localparam int BIT_LINK = 0;

    // ====================================================================
    // Frame classification limits (bytes, frame check sequence included)
    // ====================================================================
    localparam logic [13:0] LEN_MIN = 14'h0040;
    localparam logic [13:0] LEN_B1 = 14'h007f;
    localparam logic [13:0] LEN_B2 = 14'h00ff;
    localparam logic [13:0] LEN_B3 = 14'h01ff;
    localparam logic [13:0] LEN_B4 = 14'h03ff;
    localparam logic [13:0] LEN_B5 = 14'h05ee;
    localparam logic [13:0] LEN_OVER = 14'h05ef;
    localparam logic [4:0] EXCESS_COLL = 5'h10;

endpackage : psmts_pkg

// >>> core/psmts_sat_counter.sv
// Saturating statistic counter with per-byte clear.
`timescale 1ns/1ps
module psmts_sat_counter
    import psmts_pkg::*;
#(
    parameter int W = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic [13:0] inc,
    input wire logic [4:0] clr_bytes,
    output logic [W-1:0] count
);

    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    logic [W-1:0] kept;
    logic [W:0] sum;

    // ====================================================================
    // Next value: clear first, then add, so an event in the clearing cycle is still counted.
    // ====================================================================
    always_comb begin
        kept = count_reg;
        for (int b = 0; b < W / 8; b++) begin
            if (clr_bytes[b]) begin
                kept[b*8 +: 8] = 8'h00;
            end
        end
        sum = {1'b0, kept} + (W + 1)'(inc);
        count_next = sum[W] ? '1 : sum[W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
        end else if (pce) begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;

endmodule : psmts_sat_counter

// >>> core/psmts_port.sv
// Port line mode, link state, station address and transmit statistics with APB access.
`timescale 1ns/1ps
module psmts_port
    import psmts_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mac_tx_en,
    input wire logic [3:0] mac_txd,
    output logic mac_rx_dv,
    output logic [3:0] mac_rxd,
    output logic line_tx_en,
    output logic [3:0] line_txd,
    input wire logic line_rx_dv,
    input wire logic [3:0] line_rxd,
    input wire logic phy_link_up,
    output logic internal_loopback,
    output logic external_loopback,
    output logic full_duplex_select,
    output logic scrambler_enable,
    output logic symbol_interface_mode,
    output logic recv_while_send,
    output logic [47:0] station_address_field,
    input wire logic tx_frame_end,
    input wire logic tx_frame_good,
    input wire logic tx_underflow,
    input wire logic tx_err_pin,
    input wire logic tx_is_multicast,
    input wire logic tx_is_broadcast,
    input wire logic tx_is_pause,
    input wire logic tx_first_deferred,
    input wire logic [4:0] tx_coll_count,
    input wire logic [13:0] tx_frame_len,
    input wire logic tx_collision,
    input wire logic tx_late_coll
);

    // ====================================================================
    // Address decode
    // ====================================================================
    function automatic logic [6:0] stat_word(input logic [11:0] ofs);
        // Returns {hit, high word of byte counter, index}; five index bits reach all counters.
        logic [6:0] r;
        r = 7'h00;
        for (int k = 0; k < NUM_CNT; k++) begin
            if (ofs == CNT_OFS[k]) begin
                r = {1'b1, 1'b0, 5'(k)};
            end
        end
        if (ofs == OFS_BYTES_HI) begin
            r = {1'b1, 1'b1, 5'(IDX_BYTES)};
        end
        return r;
    endfunction : stat_word

    logic setup_phase;
    logic access_wr;
    logic in_clr_win;
    logic in_keep_win;
    logic [11:0] stat_ofs;
    logic [6:0] sw;
    logic stat_hit;

    assign setup_phase = pce && psel && !penable;
    assign access_wr = pce && psel && penable && pwrite;
    assign in_clr_win = paddr >= STAT_CLR_BASE && paddr < STAT_KEEP_BASE;
    assign in_keep_win = paddr >= STAT_KEEP_BASE && paddr < STAT_KEEP_BASE + STAT_CLR_BASE;
    assign stat_ofs = in_clr_win ? paddr - STAT_CLR_BASE : paddr - STAT_KEEP_BASE;
    assign sw = stat_word(stat_ofs);
    assign stat_hit = (in_clr_win || in_keep_win) && sw[6];

    // ====================================================================
    // Configuration registers
    // ====================================================================
    logic [7:0] mode_reg;
    logic [7:0] mode_next;
    logic [47:0] sa_reg;
    logic [47:0] sa_next;
    logic link_reg;
    logic link_next;

    always_comb begin
        mode_next = mode_reg;
        sa_next = sa_reg;
        link_next = mode_reg[BIT_SYP] && phy_link_up;
        if (access_wr && paddr == ADDR_MODE && pstrb[0]) begin
            mode_next = pwdata[7:0] & MODE_WMASK;
        end
        if (access_wr && paddr == ADDR_SA_LO) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb[b]) begin
                    sa_next[b*8 +: 8] = pwdata[b*8 +: 8];
                end
            end
        end
        if (access_wr && paddr == ADDR_SA_HI) begin
            for (int b = 0; b < 2; b++) begin
                if (pstrb[b]) begin
                    sa_next[32 + b*8 +: 8] = pwdata[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= MODE_RESET;
            sa_reg <= SA_RESET;
            link_reg <= 1'b0;
        end else if (pce) begin
            mode_reg <= mode_next;
            sa_reg <= sa_next;
            link_reg <= link_next;
        end
    end

    assign internal_loopback = mode_reg[BIT_INTERNAL_LOOPBACK];
    assign external_loopback = mode_reg[BIT_EXTERNAL_LOOPBACK];
    assign full_duplex_select = mode_reg[BIT_FDX];
    assign scrambler_enable = mode_reg[BIT_SCR] && mode_reg[BIT_SYP];
    assign symbol_interface_mode = mode_reg[BIT_SYP];
    // Receive stays open during transmit in duplex or either loopback.
    assign recv_while_send = mode_reg[BIT_FDX] || mode_reg[BIT_EXTERNAL_LOOPBACK] || mode_reg[BIT_INTERNAL_LOOPBACK];
    assign station_address_field = sa_reg;

    // ====================================================================
    // Line path with loopback
    // ====================================================================
    logic line_tx_en_reg;
    logic line_tx_en_next;
    logic [3:0] line_txd_reg;
    logic [3:0] line_txd_next;
    logic rx_dv_reg;
    logic rx_dv_next;
    logic [3:0] rxd_reg;
    logic [3:0] rxd_next;

    always_comb begin
        line_tx_en_next = mac_tx_en;
        line_txd_next = mac_txd;
        rx_dv_next = line_rx_dv;
        rxd_next = line_rxd;
        if (mode_reg[BIT_INTERNAL_LOOPBACK]) begin
            rx_dv_next = mac_tx_en;
            rxd_next = mac_txd;
            if (!mode_reg[BIT_SYP]) begin
                line_tx_en_next = 1'b0;
                line_txd_next = 4'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_tx_en_reg <= 1'b0;
            line_txd_reg <= 4'h0;
            rx_dv_reg <= 1'b0;
            rxd_reg <= 4'h0;
        end else if (pce) begin
            line_tx_en_reg <= line_tx_en_next;
            line_txd_reg <= line_txd_next;
            rx_dv_reg <= rx_dv_next;
            rxd_reg <= rxd_next;
        end
    end

    assign line_tx_en = line_tx_en_reg;
    assign line_txd = line_txd_reg;
    assign mac_rx_dv = rx_dv_reg;
    assign mac_rxd = rxd_reg;

    // ====================================================================
    // Transmit events and statistic counters
    // ====================================================================
    logic [13:0] inc [NUM_CNT];
    logic [4:0] clr [NUM_CNT];
    logic [39:0] cnt_val [NUM_CNT];
    logic tx_bad;
    logic tx_ok;

    assign tx_bad = tx_underflow || tx_err_pin;
    assign tx_ok = tx_frame_end && tx_frame_good && !tx_bad;

    always_comb begin
        for (int k = 0; k < NUM_CNT; k++) begin
            inc[k] = 14'h0000;
            clr[k] = 5'h00;
        end
        inc[IDX_UNI] = {13'h0000, tx_ok && !tx_is_multicast && !tx_is_broadcast};
        inc[IDX_MLT] = {13'h0000, tx_ok && tx_is_multicast && !tx_is_broadcast};
        inc[IDX_BRD] = {13'h0000, tx_ok && tx_is_broadcast};
        inc[IDX_DEFER] = {13'h0000, tx_frame_end && tx_first_deferred};
        inc[IDX_COLL] = {13'h0000, tx_collision};
        inc[IDX_SCOL] = {13'h0000, tx_ok && tx_coll_count == 5'h01};
        inc[IDX_MCOL] = {13'h0000, tx_ok && tx_coll_count > 5'h01};
        inc[IDX_XCOL] = {13'h0000, tx_frame_end && tx_coll_count >= EXCESS_COLL};
        inc[IDX_LCOL] = {13'h0000, tx_late_coll};
        inc[IDX_BIN0] = {13'h0000, tx_frame_end && tx_frame_len == LEN_MIN};
        inc[IDX_BIN0 + 1] = {13'h0000, tx_frame_end && tx_frame_len > LEN_MIN
            && tx_frame_len <= LEN_B1};
        inc[IDX_BIN0 + 2] = {13'h0000, tx_frame_end && tx_frame_len > LEN_B1
            && tx_frame_len <= LEN_B2};
        inc[IDX_BIN0 + 3] = {13'h0000, tx_frame_end && tx_frame_len > LEN_B2
            && tx_frame_len <= LEN_B3};
        inc[IDX_BIN0 + 4] = {13'h0000, tx_frame_end && tx_frame_len > LEN_B3
            && tx_frame_len <= LEN_B4};
        inc[IDX_BIN0 + 5] = {13'h0000, tx_frame_end && tx_frame_len > LEN_B4
            && tx_frame_len <= LEN_B5};
        inc[IDX_OVER] = {13'h0000, tx_frame_end && tx_frame_len > LEN_OVER};
        inc[IDX_PAUSE] = {13'h0000, tx_ok && tx_is_pause};
        inc[IDX_ERR] = {13'h0000, tx_frame_end && tx_bad};
        // The frame length already holds the FCS and no preamble.
        inc[IDX_BYTES] = tx_ok ? tx_frame_len : 14'h0000;
        // Clear happens at the setup edge, together with the data capture.
        if (setup_phase && !pwrite && in_clr_win && sw[6]) begin
            clr[sw[4:0]] = sw[5] ? 5'h10 : 5'h0f;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
            localparam int CW = (gi == IDX_BYTES) ? BYTE_CW : FRAME_CW;
            logic [CW-1:0] q;
            psmts_sat_counter #(
                .W(CW)
            ) u_cnt (
                .pclk(pclk),
                .presetn(presetn),
                .pce(pce),
                .inc(inc[gi]),
                .clr_bytes(clr[gi]),
                .count(q)
            );
            assign cnt_val[gi] = 40'(q);
        end
    endgenerate

    // ====================================================================
    // APB read data and error, captured in the setup cycle
    // ====================================================================
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic err_reg;
    logic err_next;

    always_comb begin
        rdata_next = rdata_reg;
        err_next = err_reg;
        if (setup_phase) begin
            rdata_next = 32'h0000_0000;
            err_next = 1'b0;
            if (stat_hit) begin
                err_next = pwrite;
                rdata_next = sw[5] ? {24'h00_0000, cnt_val[sw[4:0]][39:32]}
                                   : cnt_val[sw[4:0]][31:0];
            end else if (paddr == ADDR_MODE) begin
                rdata_next = {24'h00_0000, mode_reg};
            end else if (paddr == ADDR_LINK) begin
                err_next = pwrite;
                rdata_next = {31'h0000_0000, link_reg};
            end else if (paddr == ADDR_SA_LO) begin
                rdata_next = sa_reg[31:0];
            end else if (paddr == ADDR_SA_HI) begin
                rdata_next = {16'h0000, sa_reg[47:32]};
            end else begin
                err_next = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= 32'h0000_0000;
            err_reg <= 1'b0;
        end else if (pce) begin
            rdata_reg <= rdata_next;
            err_reg <= err_next;
        end
    end

    assign prdata = rdata_reg;
    assign pready = pce;
    assign pslverr = err_reg && psel && penable;

    // ====================================================================
    // Checks
    // ====================================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_internal_loopback_line_quiet: assert property (
        pce && mode_reg[BIT_INTERNAL_LOOPBACK] && !mode_reg[BIT_SYP] |=> !line_tx_en)
        else $error("line driven during internal loopback");
    a_internal_loopback_rx_loop: assert property (
        pce && mode_reg[BIT_INTERNAL_LOOPBACK] |=> mac_rx_dv == $past(mac_tx_en) && mac_rxd == $past(mac_txd))
        else $error("loopback receive does not follow transmit");
    a_scr_gated: assert property (
        scrambler_enable |-> symbol_interface_mode && mode_reg[BIT_SCR])
        else $error("scrambler active outside symbol mode");
    a_link_state: assert property (
        pce |=> link_reg == ($past(mode_reg[BIT_SYP]) && $past(phy_link_up)))
        else $error("link state wrong");
    a_mode_reserved: assert property (
        (mode_reg & ~MODE_WMASK) == 8'h00)
        else $error("reserved mode bits set");
    a_stat_clear: assert property (
        setup_phase && !pwrite && paddr == STAT_CLR_BASE && inc[IDX_UNI] == 14'h0000
        |=> cnt_val[IDX_UNI] == 40'h0)
        else $error("read through clear base did not clear");
    a_stat_keep: assert property (
        setup_phase && !pwrite && paddr == STAT_KEEP_BASE && inc[IDX_UNI] == 14'h0000
        |=> $stable(cnt_val[IDX_UNI]))
        else $error("read through keep base changed counter");
    a_coll_sat: assert property (
        pce && clr[IDX_COLL] == 5'h00
        |=> cnt_val[IDX_COLL] >= $past(cnt_val[IDX_COLL]))
        else $error("collision counter wrapped");
    a_uni_count: assert property (
        pce && inc[IDX_UNI] == 14'h0001 && clr[IDX_UNI] == 5'h00
        && cnt_val[IDX_UNI][31:0] != 32'hffff_ffff
        |=> cnt_val[IDX_UNI] == $past(cnt_val[IDX_UNI]) + 40'h1)
        else $error("unicast counter missed a frame");
    a_unmapped_err: assert property (
        setup_phase && paddr == 12'h0f0 ##1 psel && penable |-> pslverr)
        else $error("unmapped address not refused");

    c_clear_read: cover property (setup_phase && !pwrite && in_clr_win && stat_hit);
    c_internal_loopback_frame: cover property (mode_reg[BIT_INTERNAL_LOOPBACK] && mac_tx_en);
    c_good_bytes: cover property (tx_ok && tx_frame_len > LEN_MIN);
    c_excess: cover property (inc[IDX_XCOL] == 14'h0001);

endmodule : psmts_port

// >>> test/psmts_phy_model.sv
// Behavioural physical-layer device on the port's line side.
`timescale 1ns/1ps
module psmts_phy_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_en,
    input wire logic [3:0] txd,
    input wire logic loop_en,
    input wire logic inject,
    input wire logic link_good,
    output logic rx_dv,
    output logic [3:0] rxd,
    output logic link_up
);
    // Idle receive data toggles every cycle so a stale nibble never looks like data.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_dv <= 1'b0;
            rxd <= 4'h0;
        end else if (loop_en && tx_en) begin
            rx_dv <= 1'b1;
            rxd <= txd;
        end else if (inject) begin
            rx_dv <= 1'b1;
            rxd <= 4'ha;
        end else begin
            rx_dv <= 1'b0;
            rxd <= ~rxd;
        end
    end
    assign link_up = link_good;
endmodule : psmts_phy_model

// >>> test/tb_port_serial_mode_and_tx_stats.sv
// Self-checking bench for the port line mode, station address and transmit statistics.
`timescale 1ns/1ps
module tb_port_serial_mode_and_tx_stats
    import psmts_pkg::*;
;
    typedef struct packed {
        logic [7:0] fl;
        logic [4:0] nc;
        logic [13:0] len;
        logic [11:0] ad;
        logic [31:0] ex;
    } psmts_row_s;
    psmts_row_s rows [26] = '{
        '{8'hc0, 5'h00, 14'h040, 12'h100, 32'h1}, '{8'hc8, 5'h00, 14'h041, 12'h104, 32'h1},
        '{8'hcc, 5'h00, 14'h07f, 12'h108, 32'h1}, '{8'ha8, 5'h00, 14'h080, 12'h104, 32'h0},
        '{8'hd0, 5'h00, 14'h100, 12'h144, 32'h2}, '{8'hc1, 5'h00, 14'h1ff, 12'h10c, 32'h1},
        '{8'hc0, 5'h01, 14'h200, 12'h114, 32'h1}, '{8'hc0, 5'h02, 14'h3ff, 12'h118, 32'h1},
        '{8'h80, 5'h10, 14'h400, 12'h11c, 32'h1}, '{8'hca, 5'h00, 14'h5ee, 12'h140, 32'h1},
        '{8'hc0, 5'h00, 14'h5f0, 12'h13c, 32'h1}, '{8'hc0, 5'h00, 14'h5ef, 12'h13c, 32'h0},
        '{8'h00, 5'h00, 14'h000, 12'h200, 32'h5}, '{8'h00, 5'h00, 14'h000, 12'h100, 32'h5},
        '{8'h00, 5'h00, 14'h000, 12'h100, 32'h0}, '{8'h00, 5'h00, 14'h000, 12'h124, 32'h1},
        '{8'h00, 5'h00, 14'h000, 12'h128, 32'h2}, '{8'h00, 5'h00, 14'h000, 12'h12c, 32'h1},
        '{8'h00, 5'h00, 14'h000, 12'h130, 32'h2}, '{8'h00, 5'h00, 14'h000, 12'h134, 32'h2},
        '{8'h00, 5'h00, 14'h000, 12'h138, 32'h2}, '{8'h00, 5'h00, 14'h000, 12'h110, 32'h13},
        '{8'h00, 5'h00, 14'h000, 12'h260, 32'h1acb}, '{8'h00, 5'h00, 14'h000, 12'h264, 32'h0},
        '{8'h00, 5'h00, 14'h000, 12'h160, 32'h1acb}, '{8'h00, 5'h00, 14'h000, 12'h160, 32'h0}};
    logic pclk = 1'b0, presetn = 1'b0, pce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [3:0] pstrb = 4'hf, mac_txd = 4'h0, mac_rxd, line_txd, line_rxd;
    logic pready, pslverr, mac_rx_dv, line_tx_en, line_rx_dv, phy_link_up, err;
    logic mac_tx_en = 1'b0, loop_en = 1'b0, inject = 1'b0, link_good = 1'b0;
    logic internal_loopback, external_loopback, full_duplex_select, scrambler_enable;
    logic symbol_interface_mode, recv_while_send;
    logic [47:0] station_address_field;
    logic tx_frame_end = 1'b0, tx_frame_good = 1'b0, tx_underflow = 1'b0, tx_err_pin = 1'b0;
    logic tx_is_multicast = 1'b0, tx_is_broadcast = 1'b0, tx_is_pause = 1'b0;
    logic tx_first_deferred = 1'b0, tx_collision = 1'b0, tx_late_coll = 1'b0;
    logic [4:0] tx_coll_count = 5'h00;
    logic [13:0] tx_frame_len = 14'h0000;
    int error_cnt = 0, tests_run = 0, cyc = 0;

    psmts_port DUT (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .mac_tx_en, .mac_txd, .mac_rx_dv, .mac_rxd, .line_tx_en,
        .line_txd, .line_rx_dv, .line_rxd, .phy_link_up, .internal_loopback, .external_loopback,
        .full_duplex_select, .scrambler_enable, .symbol_interface_mode, .recv_while_send,
        .station_address_field, .tx_frame_end, .tx_frame_good, .tx_underflow, .tx_err_pin,
        .tx_is_multicast, .tx_is_broadcast, .tx_is_pause, .tx_first_deferred, .tx_coll_count,
        .tx_frame_len, .tx_collision, .tx_late_coll);
    psmts_phy_model phy (.pclk, .presetn, .tx_en(line_tx_en), .txd(line_txd), .loop_en,
        .inject, .link_good, .rx_dv(line_rx_dv), .rxd(line_rxd), .link_up(phy_link_up));

    // ====================================================================
    // Clock, watchdog and shared tasks
    // ====================================================================
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] ex);
        apb(1'b0, a, 32'h0);
        chk(q, ex);
    endtask : rd

    task automatic frame(input psmts_row_s r);
        @(posedge pclk);
        repeat (r.nc) begin
            tx_collision <= 1'b1;
            @(posedge pclk);
            tx_collision <= 1'b0;
            @(posedge pclk);
        end
        tx_frame_end <= 1'b1;
        {tx_frame_good, tx_underflow, tx_err_pin, tx_is_multicast} <= r.fl[6:3];
        {tx_is_broadcast, tx_is_pause, tx_first_deferred} <= r.fl[2:0];
        tx_coll_count <= r.nc;
        tx_frame_len <= r.len;
        @(posedge pclk);
        tx_frame_end <= 1'b0;
    endtask : frame

    // ====================================================================
    // Main sequence
    // ====================================================================
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({recv_while_send, mac_rx_dv, line_tx_en, symbol_interface_mode}, 4'h0);
        foreach (rows[i]) begin
            if (rows[i].fl[7]) begin
                frame(rows[i]);
            end
            rd(rows[i].ad, rows[i].ex);
        end
        rd(ADDR_MODE, 32'h0);
        rd(ADDR_SA_HI, 32'h0);
        apb(1'b1, ADDR_MODE, 32'hff);
        rd(ADDR_MODE, 32'h3b);
        chk({internal_loopback, external_loopback, full_duplex_select, scrambler_enable,
            symbol_interface_mode, recv_while_send}, 6'h3f);
        apb(1'b1, ADDR_MODE, 32'h02);
        link_good <= 1'b1;
        repeat (2) @(negedge pclk);
        chk({scrambler_enable, symbol_interface_mode, recv_while_send}, 3'h0);
        rd(ADDR_LINK, 32'h0);
        apb(1'b1, ADDR_MODE, 32'h03);
        rd(ADDR_LINK, 32'h1);
        apb(1'b1, ADDR_LINK, 32'h0);
        chk(err, 1'b1);
        apb(1'b0, 12'h0f0, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, ADDR_SA_LO, 32'h89abcdef);
        apb(1'b1, ADDR_SA_HI, 32'h4567);
        rd(ADDR_SA_HI, 32'h4567);
        chk(station_address_field, 48'h456789abcdef);
        apb(1'b1, ADDR_MODE, 32'h20);
        mac_tx_en <= 1'b1;
        mac_txd <= 4'h5;
        inject <= 1'b1;
        repeat (3) @(negedge pclk);
        chk({line_tx_en, mac_rx_dv, mac_rxd}, 6'h15);
        apb(1'b1, ADDR_MODE, 32'h21);
        repeat (2) @(negedge pclk);
        chk({line_tx_en, line_txd}, 5'h15);
        apb(1'b1, ADDR_MODE, 32'h10);
        {loop_en, inject, mac_txd} <= 6'h29;
        repeat (4) @(negedge pclk);
        chk({line_tx_en, mac_rx_dv, mac_rxd, recv_while_send}, 7'h73);
        @(posedge pclk);
        tx_late_coll <= 1'b1;
        @(posedge pclk);
        tx_late_coll <= 1'b0;
        rd(12'h120, 32'h1);
        // A late collision while the clock enable is low must leave the counter frozen.
        @(posedge pclk);
        pce <= 1'b0;
        tx_late_coll <= 1'b1;
        @(posedge pclk);
        pce <= 1'b1;
        tx_late_coll <= 1'b0;
        rd(12'h120, 32'h0);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_MODE, 32'h0);
        tally_and_finish();
    end
endmodule : tb_port_serial_mode_and_tx_stats
